// [hdl/lane1_cond_pkg.sv]
package lane1_cond_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 5;

    // register offsets
    localparam logic [7:0] OFF_OUTPUT_IDLE_CTRL = 8'h23;
    localparam logic [7:0] OFF_INPUT_EQ_CTRL = 8'h24;
    localparam logic [7:0] OFF_OUTPUT_SWING_CTRL_A = 8'h25;
    localparam logic [7:0] OFF_OUTPUT_SWING_CTRL_B = 8'h26;
    localparam logic [7:0] OFF_INPUT_IDLE_THRESHOLD = 8'h27;

    // register indices into the bank
    localparam int IDX_IDLE = 0;
    localparam int IDX_EQ = 1;
    localparam int IDX_SWING_A = 2;
    localparam int IDX_SWING_B = 3;
    localparam int IDX_THRESH = 4;

    // reset values
    localparam logic [7:0] RST_OUTPUT_IDLE_CTRL = 8'h00;
    localparam logic [7:0] RST_INPUT_EQ_CTRL = 8'h20;
    localparam logic [7:0] RST_OUTPUT_SWING_CTRL_A = 8'h03;
    localparam logic [7:0] RST_OUTPUT_SWING_CTRL_B = 8'h03;
    localparam logic [7:0] RST_INPUT_IDLE_THRESHOLD = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // field positions
    localparam int IDLE_AUTO_BIT = 5;
    localparam int IDLE_FORCE_BIT = 4;
    localparam int EQ_EN_BIT = 5;
    localparam int EQ_GST_HI = 4;
    localparam int EQ_GST_LO = 3;
    localparam int EQ_BST_HI = 2;
    localparam int EQ_BST_LO = 0;
    localparam int EQ_FIELD_HI = 5;
    localparam int SWING_A_HI = 6;
    localparam int THR_DEASSERT_HI = 3;
    localparam int THR_DEASSERT_LO = 2;
    localparam int THR_ASSERT_HI = 1;
    localparam int THR_ASSERT_LO = 0;

    // equalizer code space
    localparam int EQ_STAGES = 3;
    localparam int EQ_BOOSTS = 8;
    localparam int EQ_LEVELS = 24;
    localparam logic [5:0] EQ_CODE_BYPASS = 6'h20;
    localparam logic [5:0] EQ_CODE_5DB = 6'h2a;
    localparam logic [5:0] EQ_CODE_9DB = 6'h30;
    localparam logic [5:0] EQ_CODE_11P7DB = 6'h32;
    localparam logic [5:0] EQ_CODE_14P6DB = 6'h39;
    localparam logic [5:0] EQ_CODE_18P4DB = 6'h35;
    localparam logic [5:0] EQ_CODE_20DB = 6'h37;
    localparam logic [5:0] EQ_CODE_21P2DB = 6'h3b;
    localparam logic [5:0] EQ_CODE_28P4DB = 6'h3d;

    // swing codes
    localparam logic [6:0] SWING_CODE_600MV = 7'h03;
    localparam logic [6:0] SWING_CODE_800MV = 7'h07;

    // idle thresholds in mV, indexed by 2-bit code
    localparam logic [7:0] THR_DEASSERT_MV [4] = '{8'h6e, 8'h96, 8'haa, 8'hbe};
    localparam logic [7:0] THR_ASSERT_MV [4] = '{8'h46, 8'h6e, 8'h82, 8'h96};

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic idle_auto;
        logic idle_force;
        logic eq_enable;
        logic [1:0] eq_gain_stage;
        logic [2:0] eq_boost_level;
        logic [6:0] swing_control_a_field;
        logic [7:0] swing_control_b_field;
        logic [1:0] deassert_sel;
        logic [1:0] assert_sel;
    } conditioning_type;

    typedef struct packed {
        logic [4:0] eq_level_index;
        logic eq_level_valid;
        logic eq_bypass;
        logic eq_code_documented;
        logic eq_max_boost;
        logic [7:0] deassert_mv;
        logic [7:0] assert_mv;
    } decoded_type;

    typedef struct packed {
        logic [NUM_REGS-1:0][DATA_W-1:0] bank;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic rhit;
        decoded_type dec;
    } state_type;

endpackage

// [hdl/lane1_conditioning_decode.sv]
`timescale 1ns/1ns
`default_nettype none
module lane1_conditioning_decode (
    input wire lane1_cond_pkg::conditioning_type cfg, // live settings
    output var lane1_cond_pkg::decoded_type dec // decoded view
);
    logic [5:0] code;

    always_comb begin
        code = {cfg.eq_enable, cfg.eq_gain_stage, cfg.eq_boost_level};
        dec = '0;
        // code 20 enables the path with no stage or boost, so it counts as bypass too
        dec.eq_bypass = !cfg.eq_enable || (code == lane1_cond_pkg::EQ_CODE_BYPASS);
        // gain stage 3 lies outside the 24-level space
        dec.eq_level_valid = cfg.eq_enable && (32'(cfg.eq_gain_stage) < lane1_cond_pkg::EQ_STAGES);
        dec.eq_level_index = 5'(32'(cfg.eq_gain_stage) * lane1_cond_pkg::EQ_BOOSTS
            + 32'(cfg.eq_boost_level));
        dec.eq_max_boost = (code == lane1_cond_pkg::EQ_CODE_28P4DB);
        case (code)
            lane1_cond_pkg::EQ_CODE_BYPASS,
            lane1_cond_pkg::EQ_CODE_5DB,
            lane1_cond_pkg::EQ_CODE_9DB,
            lane1_cond_pkg::EQ_CODE_11P7DB,
            lane1_cond_pkg::EQ_CODE_14P6DB,
            lane1_cond_pkg::EQ_CODE_18P4DB,
            lane1_cond_pkg::EQ_CODE_20DB,
            lane1_cond_pkg::EQ_CODE_21P2DB,
            lane1_cond_pkg::EQ_CODE_28P4DB: begin
                dec.eq_code_documented = 1'b1;
            end
            default: begin
                dec.eq_code_documented = 1'b0;
            end
        endcase
        dec.deassert_mv = lane1_cond_pkg::THR_DEASSERT_MV[cfg.deassert_sel];
        dec.assert_mv = lane1_cond_pkg::THR_ASSERT_MV[cfg.assert_sel];
    end
endmodule
`default_nettype wire

// [hdl/lane1_signal_conditioning_regs.sv]
// Behaviour
// - auto idle bit 1 gives automatic electrical idle; 0 hands control to bit 4.
// - manual mode: force bit 0 keeps output on, no gating; 1 mutes output.
// - equalizer field is six bits: enable bit 5, gain stage 4:3, boost 2:0.
// - equalizer offers 24 levels, three gain stages of eight boosts each.
// - equalizer register resets to 0x20, meaning equalizer bypassed.
// - codes 2a,30,32,39,35,37,3b are accepted boost settings, 5 to 21.2 dB.
// - code 3d selects the strongest boost, 28.4 dB.
// - swing control a uses bits 6:0, resets to 03 (600 mV); 07 is 800 mV.
// - swing control b is a full eight-bit field resetting to 0x03.
// - threshold bits 3:2 pick de-assert level, bits 1:0 pick assert level.
`timescale 1ns/1ns
`default_nettype none
module lane1_signal_conditioning_regs #(
    parameter int ADDR_W = lane1_cond_pkg::ADDR_W,
    parameter int DATA_W = lane1_cond_pkg::DATA_W
) (
    input wire logic clk, // management clock
    input wire logic reset, // synchronous, active high
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    input wire logic [ADDR_W-1:0] reg_addr, // register offset
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    output logic [DATA_W-1:0] reg_rdata, // read data, registered
    output logic reg_rvalid, // read data valid pulse
    output logic reg_rhit, // read hit a mapped offset
    input wire logic idle_detected, // analog idle detector says idle
    output logic output_mute, // lane output in electrical idle
    output logic signal_detect_gate_en, // idle detection gates output
    output logic output_auto_idle, // automatic idle selected
    output logic eq_enable, // equalizer enabled
    output logic [1:0] eq_gain_stage, // equalizer gain stage
    output logic [2:0] eq_boost_level, // boost within stage
    output logic [4:0] eq_level_index, // flat level, stage times eight plus boost, 0..31
    output logic eq_level_valid, // index inside the level space
    output logic eq_bypass, // equalizer bypassed
    output logic eq_code_documented, // code among the known settings
    output logic eq_max_boost, // strongest boost selected
    output logic [6:0] swing_control_a_field, // output swing control a
    output logic [7:0] swing_control_b_field, // output swing control b
    output logic [1:0] idle_deassert_sel, // de-assert threshold code
    output logic [1:0] idle_assert_sel, // assert threshold code
    output logic [7:0] idle_deassert_mv, // de-assert threshold in mV
    output logic [7:0] idle_assert_mv // assert threshold in mV
);
    lane1_cond_pkg::state_type state_r;
    lane1_cond_pkg::state_type state_nxt;
    lane1_cond_pkg::reg_req_type req;
    lane1_cond_pkg::conditioning_type cfg;
    lane1_cond_pkg::decoded_type dec;
    logic [lane1_cond_pkg::NUM_REGS-1:0] sel;
    logic [DATA_W-1:0] rd_mux;

    localparam logic [7:0] OFFSETS [lane1_cond_pkg::NUM_REGS] = '{
        lane1_cond_pkg::OFF_OUTPUT_IDLE_CTRL,
        lane1_cond_pkg::OFF_INPUT_EQ_CTRL,
        lane1_cond_pkg::OFF_OUTPUT_SWING_CTRL_A,
        lane1_cond_pkg::OFF_OUTPUT_SWING_CTRL_B,
        lane1_cond_pkg::OFF_INPUT_IDLE_THRESHOLD
    };
    localparam logic [7:0] RESETS [lane1_cond_pkg::NUM_REGS] = '{
        lane1_cond_pkg::RST_OUTPUT_IDLE_CTRL,
        lane1_cond_pkg::RST_INPUT_EQ_CTRL,
        lane1_cond_pkg::RST_OUTPUT_SWING_CTRL_A,
        lane1_cond_pkg::RST_OUTPUT_SWING_CTRL_B,
        lane1_cond_pkg::RST_INPUT_IDLE_THRESHOLD
    };

    always_comb begin
        req.wr = reg_wr;
        req.rd = reg_rd;
        req.addr = reg_addr;
        req.wdata = reg_wdata;
    end

    // one comparator per register
    genvar gi;
    generate
        for (gi = 0; gi < lane1_cond_pkg::NUM_REGS; gi++) begin : g_sel
            assign sel[gi] = (req.addr == ADDR_W'(OFFSETS[gi]));
        end
    endgenerate

    always_comb begin
        rd_mux = lane1_cond_pkg::READ_UNMAPPED;
        for (int i = 0; i < lane1_cond_pkg::NUM_REGS; i++) begin
            if (sel[i]) begin
                rd_mux = state_r.bank[i];
            end
        end
    end

    // live settings straight from the bank, no commit step
    always_comb begin
        cfg.idle_auto = state_r.bank[lane1_cond_pkg::IDX_IDLE][lane1_cond_pkg::IDLE_AUTO_BIT];
        cfg.idle_force = state_r.bank[lane1_cond_pkg::IDX_IDLE][lane1_cond_pkg::IDLE_FORCE_BIT];
        cfg.eq_enable = state_r.bank[lane1_cond_pkg::IDX_EQ][lane1_cond_pkg::EQ_EN_BIT];
        cfg.eq_gain_stage = state_r.bank[lane1_cond_pkg::IDX_EQ]
            [lane1_cond_pkg::EQ_GST_HI:lane1_cond_pkg::EQ_GST_LO];
        cfg.eq_boost_level = state_r.bank[lane1_cond_pkg::IDX_EQ]
            [lane1_cond_pkg::EQ_BST_HI:lane1_cond_pkg::EQ_BST_LO];
        cfg.swing_control_a_field = state_r.bank[lane1_cond_pkg::IDX_SWING_A]
            [lane1_cond_pkg::SWING_A_HI:0];
        cfg.swing_control_b_field = state_r.bank[lane1_cond_pkg::IDX_SWING_B];
        cfg.deassert_sel = state_r.bank[lane1_cond_pkg::IDX_THRESH]
            [lane1_cond_pkg::THR_DEASSERT_HI:lane1_cond_pkg::THR_DEASSERT_LO];
        cfg.assert_sel = state_r.bank[lane1_cond_pkg::IDX_THRESH]
            [lane1_cond_pkg::THR_ASSERT_HI:lane1_cond_pkg::THR_ASSERT_LO];
    end

    lane1_conditioning_decode u_decode (
        .cfg(cfg),
        .dec(dec)
    );

    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = 1'b0;
        state_nxt.dec = dec;
        // reserved bits are stored as written so reads return what the host sent
        if (req.wr) begin
            for (int i = 0; i < lane1_cond_pkg::NUM_REGS; i++) begin
                if (sel[i]) begin
                    state_nxt.bank[i] = req.wdata;
                end
            end
        end
        if (req.rd) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rhit = |sel;
            state_nxt.rdata = rd_mux;
        end
        if (reset) begin
            for (int i = 0; i < lane1_cond_pkg::NUM_REGS; i++) begin
                state_nxt.bank[i] = RESETS[i];
            end
            state_nxt.rdata = '0;
            state_nxt.rvalid = 1'b0;
            state_nxt.rhit = 1'b0;
            state_nxt.dec = '0;
        end
    end

    always_ff @(posedge clk) begin
        state_r <= state_nxt;
    end

    assign reg_rdata = state_r.rdata;
    assign reg_rvalid = state_r.rvalid;
    assign reg_rhit = state_r.rhit;

    // idle selection: detector in auto mode, force bit otherwise
    always_comb begin
        output_auto_idle = cfg.idle_auto;
        signal_detect_gate_en = cfg.idle_auto;
        if (cfg.idle_auto) begin
            output_mute = idle_detected;
        end else begin
            output_mute = cfg.idle_force;
        end
    end

    assign eq_enable = cfg.eq_enable;
    assign eq_gain_stage = cfg.eq_gain_stage;
    assign eq_boost_level = cfg.eq_boost_level;
    assign swing_control_a_field = cfg.swing_control_a_field;
    assign swing_control_b_field = cfg.swing_control_b_field;
    assign idle_deassert_sel = cfg.deassert_sel;
    assign idle_assert_sel = cfg.assert_sel;

    // decoded view trails the bank by one cycle to keep it off long paths
    assign eq_level_index = state_r.dec.eq_level_index;
    assign eq_level_valid = state_r.dec.eq_level_valid;
    assign eq_bypass = state_r.dec.eq_bypass;
    assign eq_code_documented = state_r.dec.eq_code_documented;
    assign eq_max_boost = state_r.dec.eq_max_boost;
    assign idle_deassert_mv = state_r.dec.deassert_mv;
    assign idle_assert_mv = state_r.dec.assert_mv;

endmodule
`default_nettype wire

// [bench/lane1_cond_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module lane1_cond_chk #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 8
) (
    input wire logic clk, // clock
    input wire logic reset, // sync reset
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [ADDR_W-1:0] reg_addr, // offset
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_rvalid, // read valid
    input wire logic reg_rhit, // read hit
    input wire logic idle_detected, // detector
    input wire logic output_mute, // mute
    input wire logic signal_detect_gate_en, // gate
    input wire logic output_auto_idle, // auto idle
    input wire logic eq_enable, // eq on
    input wire logic [1:0] eq_gain_stage, // stage
    input wire logic [2:0] eq_boost_level, // boost
    input wire logic [4:0] eq_level_index, // level
    input wire logic eq_level_valid, // level ok
    input wire logic eq_max_boost, // max boost
    input wire logic eq_bypass, // bypass
    input wire logic [6:0] swing_control_a_field, // swing a
    input wire logic [7:0] idle_assert_mv // assert mV
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    function automatic logic [7:0] mv_a(logic [1:0] c);
        case (c)
            2'h0: return 8'h46;
            2'h1: return 8'h6e;
            2'h2: return 8'h82;
            default: return 8'h96;
        endcase
    endfunction
    sequence s_wr(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence
    a_mute_auto: assert property (output_auto_idle |-> output_mute == idle_detected)
        else $error("mute does not follow detector");
    a_manual_idle: assert property (s_wr(8'h23) ##0 !reg_wdata[5] |=> !output_auto_idle &&
        !signal_detect_gate_en && output_mute == $past(reg_wdata[4])) else $error("manual idle wrong");
    a_eq_fields: assert property (s_wr(8'h24) |=>
        {eq_enable, eq_gain_stage, eq_boost_level} == $past(reg_wdata[5:0])) else $error("eq fields wrong");
    a_eq_max: assert property (s_wr(8'h24) |=> ##1 eq_max_boost == ($past(reg_wdata[5:0], 2) == 6'h3d))
        else $error("max boost wrong");
    a_eq_level: assert property (s_wr(8'h24) |=> ##1 eq_level_index == $past(reg_wdata[4:0], 2) &&
        eq_level_valid == ($past(reg_wdata[5], 2) && $past(reg_wdata[4:3], 2) != 2'h3))
        else $error("eq level wrong");
    a_eq_bypass: assert property (s_wr(8'h24) |=> ##1 eq_bypass ==
        (!$past(reg_wdata[5], 2) || $past(reg_wdata[5:0], 2) == 6'h20)) else $error("bypass wrong");
    a_swing_a: assert property (s_wr(8'h25) |=> swing_control_a_field == $past(reg_wdata[6:0]))
        else $error("swing a wrong");
    a_thr_mv: assert property (s_wr(8'h27) |=> ##1 idle_assert_mv == mv_a($past(reg_wdata[1:0], 2)))
        else $error("assert threshold wrong");
    a_read_pulse: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
        else $error("read valid wrong");
    a_read_hit: assert property (reg_rd |=> reg_rhit == ($past(reg_addr) inside {[8'h23:8'h27]}))
        else $error("read hit wrong");
endmodule
bind lane1_signal_conditioning_regs lane1_cond_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .clk, .reset, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rvalid, .reg_rhit, .idle_detected,
    .output_mute, .signal_detect_gate_en, .output_auto_idle, .eq_enable, .eq_gain_stage,
    .eq_boost_level, .eq_level_index, .eq_level_valid, .eq_max_boost, .eq_bypass, .swing_control_a_field,
    .idle_assert_mv);
`default_nettype wire

// [bench/mgmt_host.sv]
`timescale 1ns/1ns
`default_nettype none
module mgmt_host (
    input wire logic clk, // clock
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    output logic [7:0] reg_addr, // offset
    output logic [7:0] reg_wdata, // write data
    input wire logic [7:0] reg_rdata, // read data
    input wire logic reg_rvalid // read valid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // reserved bits cleared before sending
    function automatic logic [7:0] keep(logic [7:0] a);
        case (a)
            8'h23: return 8'h30;
            8'h24: return 8'h3f;
            8'h25: return 8'h7f;
            8'h27: return 8'h0f;
            default: return 8'hff;
        endcase
    endfunction
    task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic v);
        @(posedge clk);
        #1;
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d & keep(a);
        @(posedge clk);
        #1;
        q = reg_rdata;
        v = reg_rvalid;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // released lines show junk, not the last value
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_type;
    localparam row_type rows [20] = '{'{8'h23, 8'h20, 8'h20}, '{8'h23, 8'h10, 8'h10}, '{8'h23, 8'h00, 8'h00},
        '{8'h24, 8'h2a, 8'h2a}, '{8'h24, 8'h30, 8'h30}, '{8'h24, 8'h32, 8'h32}, '{8'h24, 8'h39, 8'h39},
        '{8'h24, 8'h35, 8'h35}, '{8'h24, 8'h37, 8'h37}, '{8'h24, 8'h3b, 8'h3b}, '{8'h24, 8'h3d, 8'h3d},
        '{8'h24, 8'h3f, 8'h3f}, '{8'h24, 8'h15, 8'h15},
        '{8'h24, 8'h20, 8'h20}, '{8'h25, 8'h07, 8'h07}, '{8'h25, 8'h03, 8'h03}, '{8'h26, 8'hff, 8'hff},
        '{8'h26, 8'h5a, 8'h5a}, '{8'h27, 8'h0f, 8'h0f}, '{8'h27, 8'h06, 8'h06}};
    localparam logic [7:0] rst_v [5] = '{8'h00, 8'h20, 8'h03, 8'h03, 8'h00};
    localparam logic [7:0] dmv [4] = '{8'h6e, 8'h96, 8'haa, 8'hbe};
    localparam logic [7:0] amv [4] = '{8'h46, 8'h6e, 8'h82, 8'h96};
    logic clk, reset, idle_detected, reg_wr, reg_rd, rvalid, rhit, mute, gate, v, doc, maxb, bypass;
    logic [1:0] d_sel, a_sel;
    logic [7:0] reg_addr, reg_wdata, rdata, swb, d_mv, a_mv, q, eq_exp;
    int error_cnt = 0;
    int n_checks = 0;
    mgmt_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));
    lane1_signal_conditioning_regs dut (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_rhit(rhit),
        .idle_detected(idle_detected), .output_mute(mute), .signal_detect_gate_en(gate),
        .output_auto_idle(), .eq_enable(), .eq_gain_stage(), .eq_boost_level(), .eq_level_index(),
        .eq_level_valid(), .eq_bypass(bypass), .eq_code_documented(doc), .eq_max_boost(maxb),
        .swing_control_a_field(), .swing_control_b_field(swb), .idle_deassert_sel(d_sel), .idle_assert_sel(a_sel),
        .idle_deassert_mv(d_mv), .idle_assert_mv(a_mv));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(8 * 4000);
        error_cnt++;
        close_out();
    end
    initial begin
        reset = 1'b1;
        idle_detected = 1'b0;
        repeat (20) @(posedge clk);
        #1 reset = 1'b0;
        for (int i = 0; i < 5; i++) begin
            host.xfer(1'b0, 1'b1, 8'h23 + 8'(i), 8'h00, q, v);
            chk(q, rst_v[i]);
        end
        chk({5'h00, doc, maxb, bypass}, 8'h05);
        for (int i = 0; i < 20; i++) begin
            host.xfer(1'b1, 1'b0, rows[i].a, rows[i].d, q, v);
            host.xfer(1'b0, 1'b1, rows[i].a, 8'h00, q, v);
            chk(q, rows[i].e);
            chk({rhit, v}, 8'h03);
            if (rows[i].a == 8'h24) begin
                eq_exp = {5'h00, (rows[i].d inside {8'h20, 8'h2a, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37, 8'h3b, 8'h3d}),
                    rows[i].d == 8'h3d, !rows[i].d[5] || rows[i].d == 8'h20};
                chk({5'h00, doc, maxb, bypass}, eq_exp);
            end
        end
        chk(swb, 8'h5a);
        for (int c = 0; c < 4; c++) begin
            host.xfer(1'b1, 1'b0, 8'h27, {4'h0, 2'(c), ~2'(c)}, q, v);
            host.xfer(1'b0, 1'b0, 8'h27, 8'h00, q, v);
            chk(d_mv, dmv[c]);
            chk(a_mv, amv[3 - c]);
            chk({4'h0, d_sel, a_sel}, {4'h0, 2'(c), ~2'(c)});
        end
        // automatic idle follows the detector, manual ignores it
        host.xfer(1'b1, 1'b0, 8'h23, 8'h20, q, v);
        idle_detected = 1'b1;
        #1 chk({7'h00, mute}, 8'h01);
        host.xfer(1'b1, 1'b0, 8'h23, 8'h00, q, v);
        chk({gate, mute}, 8'h00);
        host.xfer(1'b1, 1'b0, 8'h23, 8'h10, q, v);
        idle_detected = 1'b0;
        #1 chk({7'h00, mute}, 8'h01);
        // unmapped places: write lost, read empty
        host.xfer(1'b1, 1'b0, 8'h28, 8'hff, q, v);
        host.xfer(1'b0, 1'b1, 8'h28, 8'h00, q, v);
        chk(q, 8'h00);
        chk({rhit, v}, 8'h01);
        // read and write together return the old value
        host.xfer(1'b1, 1'b1, 8'h25, 8'h07, q, v);
        chk(q, 8'h03);
        host.xfer(1'b0, 1'b1, 8'h25, 8'h00, q, v);
        chk(q, 8'h07);
        host.xfer(1'b1, 1'b0, 8'h24, 8'h3d, q, v);
        @(posedge clk);
        #1 reset = 1'b1;
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        host.xfer(1'b0, 1'b1, 8'h26, 8'h00, q, v);
        chk(q, 8'h03);
        chk({5'h00, doc, maxb, bypass}, 8'h05);
        close_out();
    end
endmodule
`default_nettype wire
